// ===== inc/boot_cfg_pkg.sv
// package: constants and carrier types for the hub configuration boot loader
package boot_cfg_pkg;

  // ---------------------------------------------------------------
  // timing and sizes
  // ---------------------------------------------------------------
  localparam int unsigned CLK_MHZ          = 100;   // core clock rate in MHz
  localparam int unsigned PROBE_TIME_US    = 10;    // time allowed for a source to answer, in us
  localparam int unsigned PROBE_CYCLES     = PROBE_TIME_US * CLK_MHZ;
  localparam int unsigned CNT_W            = 16;    // width of the probe timer
  localparam int unsigned OTP_PAGE_BYTES   = 200;   // bytes in one otp configuration page
  localparam int unsigned OTP_PAGES        = 4;     // successive otp pages
  localparam int unsigned OTP_ADDR_W       = 10;    // byte address width into the otp store
  localparam int unsigned EEPROM_MIN_BYTES = 512;   // least capacity of a usable eeprom

  // ---------------------------------------------------------------
  // strap encodings and reset values
  // ---------------------------------------------------------------
  localparam logic [1:0] REF_SEL_12MHZ   = 2'h3;    // both select straps high
  localparam logic [1:0] REF_SEL_RST     = 2'h0;    // select value held during reset
  localparam logic       SMBUS_EN_RST    = 1'h0;    // smbus enable held during reset
  localparam logic [1:0] SYNC_RST        = 2'h0;    // synchroniser pair after reset

  // ---------------------------------------------------------------
  // configuration source chosen by the boot sequence
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    SRC_NONE,
    SRC_SPI,
    SRC_SMBUS,
    SRC_EEPROM,
    SRC_ROM
  } cfg_src_t;

  // probe answer from the outside source interface logic
  typedef struct packed {
    logic done;    // probe finished this cycle
    logic found;   // source present and valid
  } probe_rsp_t;

  // probe requests to the source interface logic
  typedef struct packed {
    logic spi;     // look for signed flash
    logic eeprom;  // look for serial eeprom
  } probe_req_t;

endpackage : boot_cfg_pkg

// ===== rtl/hub_config_boot_loader.sv
// module: power-up configuration source selection for the hub controller
//
// Summary of operation
// - probe spi flash first, need valid signature
// - no flash, then check smbus enable
// - smbus disabled, then try serial eeprom
// - nothing found, use internal rom defaults
// - valid flash enables external rom execution
// - smbus clock strap low means disabled
// - smbus enabled waits forever as slave
// - both reference straps high select 12 mhz
// - assert host attached once host detected and config done
// - one pin senses overcurrent, never driven to enable power
// - otp store is four 200-byte pages
// - suspend switches off oscillator supply
// - stay in reset while reset held low
`timescale 1ns/1ps
module hub_config_boot_loader (
  input  wire logic                            mclk_in,              // core clock, 100 mhz
  input  wire logic                            rst_in,               // async reset, active high
  input  wire logic                            reset_n_pin_in,       // device reset pin, active low
  input  wire logic                            smbus_clk_strap_in,   // smbus clock pin level
  input  wire logic [1:0]                      ref_clock_select_in,  // reference select straps
  input  wire boot_cfg_pkg::probe_rsp_t        spi_rsp_in,           // flash probe answer
  input  wire boot_cfg_pkg::probe_rsp_t        eeprom_rsp_in,        // eeprom probe answer
  input  wire logic                            smbus_cfg_done_in,    // smbus master finished config
  input  wire logic                            host_detected_in,     // upstream host detected
  input  wire logic                            port_power_req_in,    // hub wants ports powered
  input  wire logic                            port_supply_enable_sense_in, // shared pin level
  input  wire logic                            suspend_in,           // usb suspend request
  input  wire logic [1:0]                      otp_page_in,          // otp page to read
  input  wire logic [7:0]                      otp_offset_in,        // byte within the page
  output logic                                 port_supply_enable_sense_out, // shared pin drive
  output logic                                 port_supply_enable_sense_oe_out, // shared pin enable
  output logic                                 overcurrent_sense_out, // overcurrent seen
  output boot_cfg_pkg::probe_req_t             probe_req_out,        // probe requests
  output boot_cfg_pkg::cfg_src_t               cfg_src_out,          // chosen source
  output logic                                 ext_rom_en_out,       // execute from flash
  output logic                                 rom_defaults_out,     // use internal defaults
  output logic                                 smbus_slave_en_out,   // gpios act as smbus slave
  output logic                                 cfg_done_out,         // configuration complete
  output logic                                 ref_12mhz_out,        // 12 mhz reference selected
  output logic [1:0]                           ref_clock_select_out, // latched select straps
  output logic                                 host_attached_out,    // host connected indication
  output logic                                 osc_supply_en_out,    // oscillator and pll supply
  output logic [boot_cfg_pkg::OTP_ADDR_W-1:0]  otp_addr_out,         // otp byte address
  output logic                                 otp_addr_valid_out    // offset inside a page
);

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_STRAP,       // catch straps after release
    ST_SPI,         // flash probe
    ST_SMB_CHECK,   // decide on smbus
    ST_SMB_WAIT,    // slave waiting for master
    ST_EEPROM,      // eeprom probe
    ST_RUN          // configured
  } boot_state_t;

  boot_state_t                          state_ff;          // boot sequencer state
  logic [1:0]                           rstn_sync_ff;      // device reset pin synchroniser
  logic [1:0]                           smb_sync_ff;       // smbus strap synchroniser
  logic [1:0]                           ref0_sync_ff;      // select strap 0 synchroniser
  logic [1:0]                           ref1_sync_ff;      // select strap 1 synchroniser
  logic [1:0]                           pwr_sync_ff;       // shared pin synchroniser
  logic [1:0]                           host_sync_ff;      // host detect synchroniser
  logic                                 smbus_en_ff;       // latched smbus enable
  logic [1:0]                           ref_sel_ff;        // latched select straps
  logic                                 dev_rst;           // combined internal reset
  logic [boot_cfg_pkg::OTP_ADDR_W-1:0]  otp_addr;          // from the page mapper
  logic                                 otp_valid;         // from the page mapper

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  // every pin level passes two flops before anything reads it
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      rstn_sync_ff <= boot_cfg_pkg::SYNC_RST;
      smb_sync_ff  <= boot_cfg_pkg::SYNC_RST;
      ref0_sync_ff <= boot_cfg_pkg::SYNC_RST;
      ref1_sync_ff <= boot_cfg_pkg::SYNC_RST;
      pwr_sync_ff  <= boot_cfg_pkg::SYNC_RST;
      host_sync_ff <= boot_cfg_pkg::SYNC_RST;
    end else begin
      rstn_sync_ff <= {rstn_sync_ff[0], reset_n_pin_in};
      smb_sync_ff  <= {smb_sync_ff[0], smbus_clk_strap_in};
      ref0_sync_ff <= {ref0_sync_ff[0], ref_clock_select_in[0]};
      ref1_sync_ff <= {ref1_sync_ff[0], ref_clock_select_in[1]};
      pwr_sync_ff  <= {pwr_sync_ff[0], port_supply_enable_sense_in};
      host_sync_ff <= {host_sync_ff[0], host_detected_in};
    end
  end

  // device is held in reset while its pin reads low
  assign dev_rst = ~rstn_sync_ff[1];

  // ---------------------------------------------------------------
  // strap capture
  // ---------------------------------------------------------------
  // straps are caught once, on the first cycle out of reset, so a pin that
  // later doubles as smbus clock cannot change the boot decision
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      smbus_en_ff <= boot_cfg_pkg::SMBUS_EN_RST;
      ref_sel_ff  <= boot_cfg_pkg::REF_SEL_RST;
    end else if (dev_rst) begin
      smbus_en_ff <= boot_cfg_pkg::SMBUS_EN_RST;
      ref_sel_ff  <= boot_cfg_pkg::REF_SEL_RST;
    end else if (state_ff == ST_STRAP) begin
      smbus_en_ff <= smb_sync_ff[1];
      ref_sel_ff  <= {ref1_sync_ff[1], ref0_sync_ff[1]};
    end
  end

  // ---------------------------------------------------------------
  // boot sequencer
  // ---------------------------------------------------------------
  // order is flash, then smbus strap, then eeprom, then rom defaults
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      state_ff <= ST_STRAP;
    end else if (dev_rst) begin
      state_ff <= ST_STRAP;
    end else begin
      unique case (state_ff)
        ST_STRAP: begin
          state_ff <= ST_SPI;
        end
        ST_SPI: begin
          // only a signed flash counts as found
          if (spi_rsp_in.done) begin
            state_ff <= spi_rsp_in.found ? ST_RUN : ST_SMB_CHECK;
          end
        end
        ST_SMB_CHECK: begin
          state_ff <= smbus_en_ff ? ST_SMB_WAIT : ST_EEPROM;
        end
        ST_SMB_WAIT: begin
          // no timeout: stays here until the master says done
          if (smbus_cfg_done_in) begin
            state_ff <= ST_RUN;
          end
        end
        ST_EEPROM: begin
          // capacity check is the eeprom side's duty; we trust its answer
          if (eeprom_rsp_in.done) begin
            state_ff <= ST_RUN;
          end
        end
        ST_RUN: begin
          state_ff <= ST_RUN;
        end
        default: begin
          // codes past the last state are illegal; restart the sequence
          state_ff <= ST_STRAP;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // source outputs
  // ---------------------------------------------------------------
  // the source is recorded when a flash is found, at the smbus check with smbus enabled, or when the eeprom probe ends
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      cfg_src_out        <= boot_cfg_pkg::SRC_NONE;
      ext_rom_en_out     <= 1'h0;
      rom_defaults_out   <= 1'h0;
      smbus_slave_en_out <= 1'h0;
      cfg_done_out       <= 1'h0;
      probe_req_out      <= '0;
    end else if (dev_rst) begin
      cfg_src_out        <= boot_cfg_pkg::SRC_NONE;
      ext_rom_en_out     <= 1'h0;
      rom_defaults_out   <= 1'h0;
      smbus_slave_en_out <= 1'h0;
      cfg_done_out       <= 1'h0;
      probe_req_out      <= '0;
    end else begin
      probe_req_out.spi    <= (state_ff == ST_STRAP) || (state_ff == ST_SPI && !spi_rsp_in.done);
      probe_req_out.eeprom <= (state_ff == ST_SMB_CHECK && !smbus_en_ff)
                              || (state_ff == ST_EEPROM && !eeprom_rsp_in.done);
      if (state_ff == ST_SPI && spi_rsp_in.done && spi_rsp_in.found) begin
        cfg_src_out    <= boot_cfg_pkg::SRC_SPI;
        ext_rom_en_out <= 1'h1;
        cfg_done_out   <= 1'h1;
      end
      if (state_ff == ST_SMB_CHECK && smbus_en_ff) begin
        cfg_src_out        <= boot_cfg_pkg::SRC_SMBUS;
        smbus_slave_en_out <= 1'h1;
      end
      if (state_ff == ST_SMB_WAIT && smbus_cfg_done_in) begin
        cfg_done_out <= 1'h1;
      end
      if (state_ff == ST_EEPROM && eeprom_rsp_in.done) begin
        cfg_src_out      <= eeprom_rsp_in.found ? boot_cfg_pkg::SRC_EEPROM
                                                : boot_cfg_pkg::SRC_ROM;
        rom_defaults_out <= !eeprom_rsp_in.found;
        cfg_done_out     <= 1'h1;
      end
    end
  end

  // ---------------------------------------------------------------
  // reference select, host indication, port power, suspend
  // ---------------------------------------------------------------
  // shared pin: drive value is high out of reset, low in reset, and output enable stays low, so it is never driven; the power
  // controllers pull it low on overcurrent, so low while power is requested is a fault
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      ref_12mhz_out                   <= 1'h0;
      ref_clock_select_out            <= boot_cfg_pkg::REF_SEL_RST;
      host_attached_out               <= 1'h0;
      port_supply_enable_sense_out    <= 1'h0;
      port_supply_enable_sense_oe_out <= 1'h0;
      overcurrent_sense_out           <= 1'h0;
      osc_supply_en_out               <= 1'h1;
    end else if (dev_rst) begin
      ref_12mhz_out                   <= 1'h0;
      ref_clock_select_out            <= boot_cfg_pkg::REF_SEL_RST;
      host_attached_out               <= 1'h0;
      port_supply_enable_sense_out    <= 1'h0;
      port_supply_enable_sense_oe_out <= 1'h0;
      overcurrent_sense_out           <= 1'h0;
      osc_supply_en_out               <= 1'h1;
    end else begin
      ref_12mhz_out        <= (ref_sel_ff == boot_cfg_pkg::REF_SEL_12MHZ);
      ref_clock_select_out <= ref_sel_ff;
      host_attached_out    <= host_sync_ff[1] && cfg_done_out;
      port_supply_enable_sense_out    <= 1'h1;
      port_supply_enable_sense_oe_out <= 1'h0;
      overcurrent_sense_out           <= port_power_req_in && !pwr_sync_ff[1];
      osc_supply_en_out               <= !suspend_in;
    end
  end

  // ---------------------------------------------------------------
  // otp paging
  // ---------------------------------------------------------------
  otp_page_addr u_otp_page_addr (
    .page_in   (otp_page_in),
    .offset_in (otp_offset_in),
    .addr_out  (otp_addr),
    .valid_out (otp_valid)
  );

  // registered so the top outputs come from flops
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      otp_addr_out       <= '0;
      otp_addr_valid_out <= 1'h0;
    end else begin
      otp_addr_out       <= otp_addr;
      otp_addr_valid_out <= otp_valid;
    end
  end

endmodule : hub_config_boot_loader

// ===== rtl/otp_page_addr.sv
// module: maps page and offset into a byte address of the otp store
`timescale 1ns/1ps
module otp_page_addr (
  input  wire logic [1:0]                        page_in,
  input  wire logic [7:0]                        offset_in,
  output logic      [boot_cfg_pkg::OTP_ADDR_W-1:0] addr_out,
  output logic                                   valid_out
);

  // ---------------------------------------------------------------
  // address arithmetic
  // ---------------------------------------------------------------
  // pages sit back to back, so address is page times page size plus offset
  always_comb begin
    addr_out  = boot_cfg_pkg::OTP_ADDR_W'(page_in * boot_cfg_pkg::OTP_PAGE_BYTES
                + offset_in);
    valid_out = (32'(offset_in) < boot_cfg_pkg::OTP_PAGE_BYTES);
  end

endmodule : otp_page_addr

// ===== test/cfg_source_model.sv
// model: external flash and eeprom answering the loader's probes
`timescale 1ns/1ps
module cfg_source_model (
  input  wire logic                 clk_in,
  input  wire logic                 rst_in,
  input  wire boot_cfg_pkg::probe_req_t req_in,     // pending probes
  input  wire logic                 spi_ok_in,      // flash holds a valid signature
  input  wire logic                 ee_ok_in,       // eeprom present, 512 bytes or more
  input  wire logic [7:0]           lag_in,         // answer delay in cycles
  output boot_cfg_pkg::probe_rsp_t  spi_out,
  output boot_cfg_pkg::probe_rsp_t  ee_out
);
  logic [7:0] wait_ff;  // cycles spent on the current probe

  // ---------------------------------------------------------------
  // answer one probe after lag_in cycles; found is inverted outside
  // the done pulse so a loader sampling it late sees garbage
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wait_ff <= 8'h00;
      spi_out <= '0;
      ee_out  <= '0;
    end else begin
      spi_out <= '{done: 1'b0, found: ~spi_ok_in};
      ee_out  <= '{done: 1'b0, found: ~ee_ok_in};
      if ((req_in.spi || req_in.eeprom) && !spi_out.done && !ee_out.done) begin
        wait_ff <= wait_ff + 8'h01;
        if (wait_ff == lag_in) begin
          wait_ff <= 8'h00;
          if (req_in.spi)
            spi_out <= '{done: 1'b1, found: spi_ok_in};
          else
            ee_out <= '{done: 1'b1, found: ee_ok_in};
        end
      end else begin
        wait_ff <= 8'h00;
      end
    end
  end
endmodule : cfg_source_model

// ===== test/hub_config_boot_loader_chk.sv
// checker: concurrent properties on the boot loader ports
`timescale 1ns/1ps
module hub_config_boot_loader_chk (
  input wire logic                                mclk_in,
  input wire logic                                rst_in,
  input wire logic                                reset_n_pin_in,
  input wire logic                                smbus_cfg_done_in,
  input wire logic                                host_detected_in,
  input wire logic                                port_power_req_in,
  input wire logic                                suspend_in,
  input wire logic                                port_supply_enable_sense_in,
  input wire logic [1:0]                          otp_page_in,
  input wire logic [7:0]                          otp_offset_in,
  input wire boot_cfg_pkg::probe_rsp_t            spi_rsp_in,
  input wire boot_cfg_pkg::probe_rsp_t            eeprom_rsp_in,
  input wire boot_cfg_pkg::probe_req_t            probe_req_out,
  input wire boot_cfg_pkg::cfg_src_t              cfg_src_out,
  input wire logic                                ext_rom_en_out,
  input wire logic                                rom_defaults_out,
  input wire logic                                smbus_slave_en_out,
  input wire logic                                cfg_done_out,
  input wire logic                                ref_12mhz_out,
  input wire logic                                host_attached_out,
  input wire logic                                osc_supply_en_out,
  input wire logic                                overcurrent_sense_out,
  input wire logic                                port_supply_enable_sense_oe_out,
  input wire logic                                otp_addr_valid_out,
  input wire logic [1:0]                          ref_clock_select_out,
  input wire logic [boot_cfg_pkg::OTP_ADDR_W-1:0] otp_addr_out
);
  // ---------------------------------------------------------------
  // one clock domain, so clocking and disable are shared
  // ---------------------------------------------------------------
  default clocking @(posedge mclk_in); endclocking
  default disable iff (rst_in);

  spi_accept_a: assert property (
    probe_req_out.spi && spi_rsp_in.done && spi_rsp_in.found && reset_n_pin_in
    |=> ext_rom_en_out && cfg_done_out && cfg_src_out == boot_cfg_pkg::SRC_SPI) else $error("flash not taken");
  spi_reject_a: assert property (
    probe_req_out.spi && spi_rsp_in.done && !spi_rsp_in.found && reset_n_pin_in
    |=> !probe_req_out.eeprom && !smbus_slave_en_out ##1 (smbus_slave_en_out != probe_req_out.eeprom)
    && !ext_rom_en_out) else $error("fallback after flash wrong");
  smbus_wait_a: assert property (
    smbus_slave_en_out && !cfg_done_out && !smbus_cfg_done_in && reset_n_pin_in
    |=> smbus_slave_en_out && !cfg_done_out && !probe_req_out.eeprom) else $error("smbus wait left");
  eeprom_load_a: assert property (
    probe_req_out.eeprom && eeprom_rsp_in.done && eeprom_rsp_in.found && reset_n_pin_in
    |=> cfg_done_out && !rom_defaults_out && cfg_src_out == boot_cfg_pkg::SRC_EEPROM) else $error("eeprom load");
  rom_fallback_a: assert property (
    probe_req_out.eeprom && eeprom_rsp_in.done && !eeprom_rsp_in.found && reset_n_pin_in
    |=> rom_defaults_out && cfg_done_out && !probe_req_out.eeprom && cfg_src_out == boot_cfg_pkg::SRC_ROM)
    else $error("rom fallback wrong");
  strap_hold_a: assert property (
    cfg_done_out && reset_n_pin_in |=> $stable(ref_clock_select_out)
    && ref_12mhz_out == (ref_clock_select_out == boot_cfg_pkg::REF_SEL_12MHZ)) else $error("strap latch");
  host_link_a: assert property (
    (host_detected_in && cfg_done_out && reset_n_pin_in) [*3] |=> host_attached_out) else $error("host flag");
  shared_pin_a: assert property (
    (port_power_req_in && !port_supply_enable_sense_in && reset_n_pin_in) [*3]
    |=> overcurrent_sense_out && !port_supply_enable_sense_oe_out) else $error("overcurrent missed");
  osc_off_a: assert property (
    $rose(suspend_in) && reset_n_pin_in |=> !osc_supply_en_out) else $error("osc supply on in suspend");
  // the first edge after release still shows the reset value of the address flops
  otp_map_a: assert property (
    !$past(rst_in) |-> otp_addr_out == 10'($past(otp_page_in)) * 10'h0C8 + 10'($past(otp_offset_in))
    && otp_addr_valid_out == ($past(otp_offset_in) < 8'hC8)) else $error("otp address wrong");
  pin_reset_a: assert property (
    !reset_n_pin_in [*3] |=> !cfg_done_out && !ext_rom_en_out && probe_req_out == '0) else $error("pin reset");

  // main paths reached
  cover property (ext_rom_en_out);
  cover property (smbus_slave_en_out && smbus_cfg_done_in);
  cover property (rom_defaults_out);
endmodule : hub_config_boot_loader_chk

bind hub_config_boot_loader hub_config_boot_loader_chk i_hub_config_boot_loader_chk (.*);

// ===== test/hub_config_boot_loader_test.sv
// testbench: boot source selection scenarios for the configuration loader
`timescale 1ns/1ps
module hub_config_boot_loader_test;
  // ---------------------------------------------------------------
  // stimulus and observed signals
  // ---------------------------------------------------------------
  logic mclk_in, rst_in, reset_n_pin_in, smbus_clk_strap_in, smbus_cfg_done_in, host_detected_in;
  logic port_power_req_in, port_supply_enable_sense_in, suspend_in, spi_ok, ee_ok;
  logic [1:0] ref_clock_select_in, otp_page_in, ref_clock_select_out;
  logic [7:0] otp_offset_in, lag;
  boot_cfg_pkg::probe_rsp_t spi_rsp_in, eeprom_rsp_in;
  boot_cfg_pkg::probe_req_t probe_req_out;
  boot_cfg_pkg::cfg_src_t cfg_src_out;
  logic port_supply_enable_sense_out, port_supply_enable_sense_oe_out, overcurrent_sense_out;
  logic ext_rom_en_out, rom_defaults_out, smbus_slave_en_out, cfg_done_out, ref_12mhz_out;
  logic host_attached_out, osc_supply_en_out, otp_addr_valid_out;
  logic [boot_cfg_pkg::OTP_ADDR_W-1:0] otp_addr_out;
  int failures = 0;
  int check_count = 0;

  hub_config_boot_loader i_hub_config_boot_loader (.*);
  cfg_source_model i_cfg_source_model (.clk_in(mclk_in), .rst_in(rst_in), .req_in(probe_req_out),
    .spi_ok_in(spi_ok), .ee_ok_in(ee_ok), .lag_in(lag), .spi_out(spi_rsp_in), .ee_out(eeprom_rsp_in));

  initial begin
    mclk_in = 1'b0;
    forever #5 mclk_in = ~mclk_in;
  end

  // inputs always move 1 ns after the edge
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask : tick

  task automatic chk(input string what, input logic [9:0] exp, input logic [9:0] got);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk

  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : summarize

  // reset for 6 cycles, then wait bounded for the loader to settle
  task automatic boot(input logic s_ok, input logic e_ok, input logic strap, input logic [1:0] refs);
    int i;
    rst_in = 1'b1;
    spi_ok = s_ok;
    ee_ok = e_ok;
    smbus_clk_strap_in = strap;
    ref_clock_select_in = refs;
    tick(6);
    rst_in = 1'b0;
    for (i = 0; i < 300 && cfg_done_out !== 1'b1 && smbus_slave_en_out !== 1'b1; i++)
      tick(1);
    if (i == 300) begin
      failures++;
      summarize();
    end
  endtask : boot

  initial begin
    {rst_in, reset_n_pin_in, smbus_cfg_done_in, host_detected_in, suspend_in} = 5'h18;
    {port_power_req_in, port_supply_enable_sense_in, otp_page_in, otp_offset_in} = 12'h400;
    lag = 8'h00;
    // signed flash wins, straps frozen after capture
    boot(1'b1, 1'b1, 1'b1, 2'h3);
    chk("src_spi", 10'(boot_cfg_pkg::SRC_SPI), 10'(cfg_src_out));
    chk("ext_rom", 10'h001, 10'(ext_rom_en_out));
    chk("ref_12", 10'h001, 10'(ref_12mhz_out));
    ref_clock_select_in = 2'h0;
    tick(4);
    chk("ref_latched", 10'h003, 10'(ref_clock_select_out));
    $display("test flash done");
    // no flash, smbus strap high: wait without timeout, slow answers
    lag = 8'h05;
    boot(1'b0, 1'b1, 1'b1, 2'h3);
    tick(200);
    chk("slave_en", 10'h001, 10'(smbus_slave_en_out));
    chk("still_waiting", 10'h000, 10'(cfg_done_out));
    chk("no_eeprom", 10'h000, 10'(probe_req_out.eeprom));
    smbus_cfg_done_in = 1'b1;
    tick(1);
    smbus_cfg_done_in = 1'b0;
    tick(3);
    chk("src_smbus", 10'(boot_cfg_pkg::SRC_SMBUS), 10'(cfg_src_out));
    chk("smbus_done", 10'h001, 10'(cfg_done_out));
    $display("test smbus done");
    // strap low: eeprom supplies configuration
    boot(1'b0, 1'b1, 1'b0, 2'h1);
    chk("src_eeprom", 10'(boot_cfg_pkg::SRC_EEPROM), 10'(cfg_src_out));
    chk("ref_not12", 10'h000, 10'(ref_12mhz_out));
    $display("test eeprom done");
    // nothing outside: rom defaults, then pins and otp paging
    lag = 8'h00;
    boot(1'b0, 1'b0, 1'b0, 2'h3);
    chk("src_rom", 10'(boot_cfg_pkg::SRC_ROM), 10'(cfg_src_out));
    chk("rom_def", 10'h001, 10'(rom_defaults_out));
    host_detected_in = 1'b1;
    tick(4);
    chk("host", 10'h001, 10'(host_attached_out));
    {port_power_req_in, port_supply_enable_sense_in} = 2'h2;
    tick(4);
    chk("ocs_on", 10'h001, 10'(overcurrent_sense_out));
    port_supply_enable_sense_in = 1'b1;
    tick(4);
    chk("ocs_off", 10'h000, 10'(overcurrent_sense_out));
    chk("pin_oe", 10'h000, 10'(port_supply_enable_sense_oe_out));
    chk("pin_drive", 10'h001, 10'(port_supply_enable_sense_out));
    suspend_in = 1'b1;
    tick(2);
    chk("osc_off", 10'h000, 10'(osc_supply_en_out));
    suspend_in = 1'b0;
    tick(2);
    for (int p = 0; p < boot_cfg_pkg::OTP_PAGES; p++)
      for (int o = boot_cfg_pkg::OTP_PAGE_BYTES - 2; o <= boot_cfg_pkg::OTP_PAGE_BYTES; o++) begin
        otp_page_in = 2'(p);
        otp_offset_in = 8'(o);
        tick(2);
        chk("otp_addr", 10'(p * boot_cfg_pkg::OTP_PAGE_BYTES + o), otp_addr_out);
        chk("otp_valid", 10'(o < boot_cfg_pkg::OTP_PAGE_BYTES), 10'(otp_addr_valid_out));
      end
    {otp_page_in, otp_offset_in} = 10'h000;
    reset_n_pin_in = 1'b0;
    tick(4);
    chk("pin_reset", 10'h000, 10'(cfg_done_out));
    reset_n_pin_in = 1'b1;
    tick(3);
    $display("test rom and pins done");
    summarize();
  end
endmodule : hub_config_boot_loader_test
